// ---- src/crp_pkg.sv ----
// Package for the core special-register and user port block
package crp_pkg;
    // Special-register addresses
    localparam logic [7:0] ADDR_STACK_TOP = 8'h81;
    localparam logic [7:0] ADDR_PTR_LOW = 8'h82;
    localparam logic [7:0] ADDR_PTR_HIGH = 8'h83;
    localparam logic [7:0] ADDR_PINS_LOW_DATA = 8'h90;
    localparam logic [7:0] ADDR_PINS_LOW_DIR = 8'h91;
    localparam logic [7:0] ADDR_PIN_NINE_DATA = 8'ha0;
    localparam logic [7:0] ADDR_PIN_NINE_DIR = 8'ha1;
    localparam logic [7:0] ADDR_FLAGS = 8'hd0;
    localparam logic [7:0] ADDR_OPERAND = 8'he0;
    localparam logic [7:0] ADDR_AUX = 8'hf0;
    // Reset values
    localparam logic [7:0] RST_STACK_TOP = 8'h07;
    localparam logic [15:0] RST_FETCH_COUNTER = 16'h0000;
    localparam logic [7:0] RST_PINS_LOW_DATA = 8'hff;
    localparam logic [7:0] RST_PINS_LOW_DIR = 8'hff;
    localparam logic [7:0] RST_PIN_NINE_DATA = 8'h00;
    localparam logic [7:0] RST_PIN_NINE_DIR = 8'h01;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Flags word bit positions
    localparam int FLAG_CARRY = 7;
    localparam int FLAG_HALF = 6;
    localparam int FLAG_USER0 = 5;
    localparam int FLAG_BANK_HI = 4;
    localparam int FLAG_BANK_LO = 3;
    localparam int FLAG_WRAP = 2;
    localparam int FLAG_USER1 = 1;
    localparam int FLAG_PARITY = 0;
    // Bank geometry: eight bytes per bank
    localparam int BANK_SHIFT = 3;
    localparam int USER_PINS = 9;

    // Arithmetic update from the execution unit
    typedef struct packed {
        logic carry_out_flag;
        logic half_carry_flag;
        logic signed_wrap_flag;
    } crp_arith_flags_t;

    // Operations on the stack, pointer and auxiliary registers
    typedef enum logic [2:0] {
        CRP_OP_NONE,
        CRP_OP_PUSH,
        CRP_OP_POP,
        CRP_OP_LOAD_PTR16,
        CRP_OP_MULDIV
    } crp_op_t;

    // Special-register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } crp_sfr_req_t;
endpackage : crp_pkg

// ---- src/crp_user_pin.sv ----
// One bidirectional user pin: latch-driven output and synchronised input
`timescale 1ns/1ps
`default_nettype none
module crp_user_pin
    import crp_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic latch_val,
    input wire logic dir_input,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_n,
    output logic read_val
);
    // Two-flop synchroniser for the pad input
    logic sync_a;
    logic sync_b;

    // Pad input crossing; first flop feeds only the second
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= pin_in;
            sync_b <= sync_a;
        end
    end

    // Pad drive registered so outputs come from flops
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_out <= 1'b1;
            pin_oe_n <= 1'b1;
        end else begin
            pin_out <= latch_val;
            pin_oe_n <= dir_input;
        end
    end

    // Readback: latch for outputs, pad level for inputs
    always_comb begin
        read_val = dir_input ? sync_b : latch_val;
    end
endmodule : crp_user_pin
`default_nettype wire

// ---- src/crp_core_regs.sv ----
// Core special registers (flags, stack, pointer, counter) and user port
//
// Functional notes
// - Flags bits 4:3 pick working register bank
// - Parity bit keeps accumulator plus parity even
// - Flags bits 5 and 1 plain storage
// - Stack resets 0x07, increments before store
// - Pointer loads as 16 bits or bytes
// - Pointer addresses code and external data
// - Fetch counter resets zero, advances on fetch
// - Fetch counter unreachable through register space
// - Accumulator is implicit operand holder
// - Auxiliary register for multiply, divide, scratch
// - Output latch 1 drives high, 0 low
// - Latch contents appear on the pin
// - Direction 0 output, 1 input
// - Low data covers pins 0-7, 0xA0 ninth
// - Every pin bidirectional with latch and buffer
`timescale 1ns/1ps
`default_nettype none
module crp_core_regs
    import crp_pkg::*;
#(
    parameter int PINS = USER_PINS
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire crp_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input wire crp_op_t reg_op,
    input wire logic [15:0] ptr_imm,
    input wire logic [7:0] aux_result,
    input wire logic operand_we,
    input wire logic [7:0] operand_wdata,
    input wire logic arith_we,
    input wire crp_arith_flags_t arith_flags,
    input wire logic fetch_adv,
    input wire logic fetch_load,
    input wire logic [15:0] fetch_target,
    output logic [7:0] stack_top_reg,
    output logic [15:0] ext_data_pointer,
    output logic [15:0] instr_fetch_counter,
    output logic [7:0] core_flags_reg,
    output logic [7:0] main_operand_reg,
    output logic [7:0] aux_reg,
    output logic [4:0] bank_base,
    input wire logic [PINS-1:0] user_pin_in,
    output logic [PINS-1:0] user_pin_out,
    output logic [PINS-1:0] user_pin_oe_n
);
    // Writable fields of the flags word
    logic carry_out_flag;
    logic half_carry_flag;
    logic user_flag_zero;
    logic bank_sel_hi;
    logic bank_sel_lo;
    logic signed_wrap_flag;
    logic user_flag_one;
    // Pointer halves
    logic [7:0] ext_ptr_low_byte;
    logic [7:0] ext_ptr_high_byte;
    // Port latches and direction
    logic [7:0] user_pins_low_data;
    logic [7:0] user_pins_low_direction;
    logic [7:0] user_pin_nine_data;
    logic [7:0] user_pin_nine_direction;
    // Per-pin latch, direction and readback vectors
    logic [PINS-1:0] pin_latch;
    logic [PINS-1:0] pin_dir;
    logic [PINS-1:0] pin_read;
    // Next values
    logic next_parity;
    logic [7:0] next_rdata;

    // Register write strobe decode, used by every register except the fetch counter and read data
    function automatic logic hit(input crp_sfr_req_t r, input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction : hit

    // Flags word bank select and user bits
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            user_flag_zero <= 1'b0;
            bank_sel_hi <= 1'b0;
            bank_sel_lo <= 1'b0;
            user_flag_one <= 1'b0;
        end else if (hit(sfr_req, ADDR_FLAGS)) begin
            user_flag_zero <= sfr_req.wdata[FLAG_USER0];
            user_flag_one <= sfr_req.wdata[FLAG_USER1];
            bank_sel_hi <= sfr_req.wdata[FLAG_BANK_HI];
            bank_sel_lo <= sfr_req.wdata[FLAG_BANK_LO];
        end
    end

    // Arithmetic flags; instruction update wins over a software write
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            carry_out_flag <= 1'b0;
            half_carry_flag <= 1'b0;
            signed_wrap_flag <= 1'b0;
        end else if (arith_we) begin
            carry_out_flag <= arith_flags.carry_out_flag;
            half_carry_flag <= arith_flags.half_carry_flag;
            signed_wrap_flag <= arith_flags.signed_wrap_flag;
        end else if (hit(sfr_req, ADDR_FLAGS)) begin
            carry_out_flag <= sfr_req.wdata[FLAG_CARRY];
            half_carry_flag <= sfr_req.wdata[FLAG_HALF];
            signed_wrap_flag <= sfr_req.wdata[FLAG_WRAP];
        end
    end

    // Accumulator; execution path has priority over register writes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            main_operand_reg <= RST_BYTE;
        end else if (operand_we) begin
            main_operand_reg <= operand_wdata;
        end else if (hit(sfr_req, ADDR_OPERAND)) begin
            main_operand_reg <= sfr_req.wdata;
        end
    end

    // Parity follows the accumulator in the same cycle it changes
    always_comb begin
        if (operand_we) begin
            next_parity = ^operand_wdata;
        end else if (hit(sfr_req, ADDR_OPERAND)) begin
            next_parity = ^sfr_req.wdata;
        end else begin
            next_parity = ^main_operand_reg;
        end
    end

    // Flags word assembled from flops; parity written by software is ignored
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_flags_reg <= RST_BYTE;
        end else begin
            core_flags_reg[FLAG_PARITY] <= next_parity;
            core_flags_reg[FLAG_USER1] <= hit(sfr_req, ADDR_FLAGS) ?
                sfr_req.wdata[FLAG_USER1] : user_flag_one;
            core_flags_reg[FLAG_WRAP] <= arith_we ? arith_flags.signed_wrap_flag :
                hit(sfr_req, ADDR_FLAGS) ? sfr_req.wdata[FLAG_WRAP] : signed_wrap_flag;
            core_flags_reg[FLAG_BANK_LO] <= hit(sfr_req, ADDR_FLAGS) ?
                sfr_req.wdata[FLAG_BANK_LO] : bank_sel_lo;
            core_flags_reg[FLAG_BANK_HI] <= hit(sfr_req, ADDR_FLAGS) ?
                sfr_req.wdata[FLAG_BANK_HI] : bank_sel_hi;
            core_flags_reg[FLAG_USER0] <= hit(sfr_req, ADDR_FLAGS) ?
                sfr_req.wdata[FLAG_USER0] : user_flag_zero;
            core_flags_reg[FLAG_HALF] <= arith_we ? arith_flags.half_carry_flag :
                hit(sfr_req, ADDR_FLAGS) ? sfr_req.wdata[FLAG_HALF] : half_carry_flag;
            core_flags_reg[FLAG_CARRY] <= arith_we ? arith_flags.carry_out_flag :
                hit(sfr_req, ADDR_FLAGS) ? sfr_req.wdata[FLAG_CARRY] : carry_out_flag;
        end
    end

    // Working bank base address, registered from the live bank bits
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bank_base <= 5'h00;
        end else if (hit(sfr_req, ADDR_FLAGS)) begin
            bank_base <= {sfr_req.wdata[FLAG_BANK_HI:FLAG_BANK_LO], {BANK_SHIFT{1'b0}}};
        end
    end

    // Stack pointer: pre-increment on push, post-decrement on pop
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stack_top_reg <= RST_STACK_TOP;
        end else if (reg_op == CRP_OP_PUSH) begin
            stack_top_reg <= stack_top_reg + 8'h01;
        end else if (reg_op == CRP_OP_POP) begin
            stack_top_reg <= stack_top_reg - 8'h01;
        end else if (hit(sfr_req, ADDR_STACK_TOP)) begin
            stack_top_reg <= sfr_req.wdata;
        end
    end

    // Pointer halves: 16-bit immediate load or separate byte writes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_ptr_low_byte <= RST_BYTE;
            ext_ptr_high_byte <= RST_BYTE;
        end else if (reg_op == CRP_OP_LOAD_PTR16) begin
            ext_ptr_low_byte <= ptr_imm[7:0];
            ext_ptr_high_byte <= ptr_imm[15:8];
        end else begin
            if (hit(sfr_req, ADDR_PTR_LOW)) begin
                ext_ptr_low_byte <= sfr_req.wdata;
            end
            if (hit(sfr_req, ADDR_PTR_HIGH)) begin
                ext_ptr_high_byte <= sfr_req.wdata;
            end
        end
    end

    // Pointer output used as code/external data address
    always_comb begin
        ext_data_pointer = {ext_ptr_high_byte, ext_ptr_low_byte};
    end

    // Auxiliary register: multiply/divide result or scratch write
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            aux_reg <= RST_BYTE;
        end else if (reg_op == CRP_OP_MULDIV) begin
            aux_reg <= aux_result;
        end else if (hit(sfr_req, ADDR_AUX)) begin
            aux_reg <= sfr_req.wdata;
        end
    end

    // Fetch counter: no register address reaches it
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            instr_fetch_counter <= RST_FETCH_COUNTER;
        end else if (fetch_load) begin
            instr_fetch_counter <= fetch_target;
        end else if (fetch_adv) begin
            instr_fetch_counter <= instr_fetch_counter + 16'h0001;
        end
    end

    // Port latches and direction registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            user_pins_low_data <= RST_PINS_LOW_DATA;
            user_pins_low_direction <= RST_PINS_LOW_DIR;
            user_pin_nine_data <= RST_PIN_NINE_DATA;
            user_pin_nine_direction <= RST_PIN_NINE_DIR;
        end else begin
            if (hit(sfr_req, ADDR_PINS_LOW_DATA)) begin
                user_pins_low_data <= sfr_req.wdata;
            end
            if (hit(sfr_req, ADDR_PINS_LOW_DIR)) begin
                user_pins_low_direction <= sfr_req.wdata;
            end
            if (hit(sfr_req, ADDR_PIN_NINE_DATA)) begin
                user_pin_nine_data <= sfr_req.wdata;
            end
            if (hit(sfr_req, ADDR_PIN_NINE_DIR)) begin
                user_pin_nine_direction <= sfr_req.wdata;
            end
        end
    end

    // Flatten latches to per-pin vectors; ninth pin uses bit 0
    always_comb begin
        pin_latch = {user_pin_nine_data[0], user_pins_low_data};
        pin_dir = {user_pin_nine_direction[0], user_pins_low_direction};
    end

    // One pin cell per user pin
    generate
        for (genvar i = 0; i < PINS; i++) begin : g_pin
            crp_user_pin u_pin (
                .core_clk(core_clk),
                .reset_n(reset_n),
                .latch_val(pin_latch[i]),
                .dir_input(pin_dir[i]),
                .pin_in(user_pin_in[i]),
                .pin_out(user_pin_out[i]),
                .pin_oe_n(user_pin_oe_n[i]),
                .read_val(pin_read[i])
            );
        end
    endgenerate

    // Read mux; unmapped addresses, including any fetch counter, read zero
    always_comb begin
        next_rdata = 8'h00;
        unique case (sfr_req.addr)
            ADDR_STACK_TOP: next_rdata = stack_top_reg;
            ADDR_PTR_LOW: next_rdata = ext_ptr_low_byte;
            ADDR_PTR_HIGH: next_rdata = ext_ptr_high_byte;
            ADDR_PINS_LOW_DATA: next_rdata = pin_read[7:0];
            ADDR_PINS_LOW_DIR: next_rdata = user_pins_low_direction;
            ADDR_PIN_NINE_DATA: next_rdata = {user_pin_nine_data[7:1], pin_read[8]};
            ADDR_PIN_NINE_DIR: next_rdata = user_pin_nine_direction;
            ADDR_FLAGS: next_rdata = core_flags_reg;
            ADDR_OPERAND: next_rdata = main_operand_reg;
            ADDR_AUX: next_rdata = aux_reg;
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data registered one cycle after the read strobe
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_req.rd) begin
            sfr_rdata <= next_rdata;
        end
    end

    // Assertions
    sequence s_push;
        reg_op == CRP_OP_PUSH && !sfr_req.wr;
    endsequence

    AST_PARITY_EVEN: assert property (@(posedge core_clk) disable iff (!reset_n)
        ^{main_operand_reg, core_flags_reg[FLAG_PARITY]} == 1'b0)
        else $error("parity flag not even with accumulator");
    AST_STACK_INC: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_push |=> stack_top_reg == $past(stack_top_reg) + 8'h01)
        else $error("stack pointer not pre-incremented");
    AST_BANK_SEL: assert property (@(posedge core_clk) disable iff (!reset_n)
        hit(sfr_req, ADDR_FLAGS) |=> bank_base ==
        {$past(sfr_req.wdata[FLAG_BANK_HI:FLAG_BANK_LO]), {BANK_SHIFT{1'b0}}})
        else $error("bank base does not follow bank bits");
    AST_USER_FLAGS: assert property (@(posedge core_clk) disable iff (!reset_n)
        hit(sfr_req, ADDR_FLAGS) |=> core_flags_reg[FLAG_USER0] == $past(sfr_req.wdata[FLAG_USER0])
        && core_flags_reg[FLAG_USER1] == $past(sfr_req.wdata[FLAG_USER1]))
        else $error("user flags not stored");
    AST_ARITH: assert property (@(posedge core_clk) disable iff (!reset_n)
        arith_we |=> core_flags_reg[FLAG_CARRY] == $past(arith_flags.carry_out_flag)
        && core_flags_reg[FLAG_HALF] == $past(arith_flags.half_carry_flag)
        && core_flags_reg[FLAG_WRAP] == $past(arith_flags.signed_wrap_flag))
        else $error("arithmetic flags not updated");
    AST_PTR16: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_op == CRP_OP_LOAD_PTR16 |=> ext_data_pointer == $past(ptr_imm))
        else $error("pointer immediate load failed");
    AST_FETCH: assert property (@(posedge core_clk) disable iff (!reset_n)
        fetch_adv && !fetch_load |=> instr_fetch_counter == $past(instr_fetch_counter) + 16'h0001)
        else $error("fetch counter did not advance");
    AST_PIN_DRIVE: assert property (@(posedge core_clk) disable iff (!reset_n)
        hit(sfr_req, ADDR_PINS_LOW_DATA) ##1 !hit(sfr_req, ADDR_PINS_LOW_DATA)
        |=> user_pin_out[0] == $past(sfr_req.wdata[0], 2))
        else $error("pin does not follow latch");
    AST_DIR: assert property (@(posedge core_clk) disable iff (!reset_n)
        hit(sfr_req, ADDR_PINS_LOW_DIR) ##1 !hit(sfr_req, ADDR_PINS_LOW_DIR)
        |=> user_pin_oe_n[0] == $past(sfr_req.wdata[0], 2))
        else $error("pin direction wrong");
endmodule : crp_core_regs
`default_nettype wire

// ---- tb/crp_pin_model.sv ----
// Board-side model of the nine user pins: pad drivers and wire resolution
`timescale 1ns/1ps
`default_nettype none
module crp_pin_model #(
    parameter int PINS = 9
) (
    input wire logic core_clk,
    input wire logic [PINS-1:0] user_pin_out,
    input wire logic [PINS-1:0] user_pin_oe_n,
    input wire logic [PINS-1:0] ext_val,
    input wire logic [PINS-1:0] ext_en,
    output logic [PINS-1:0] pin_level,
    output logic [PINS-1:0] user_pin_in,
    output logic [PINS-1:0] clash
);
    // Last resolved level; a floating pad is made to toggle from it
    logic [PINS-1:0] last_level = '0;

    // Wire level: device driver first, then board driver, else floating
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            if (!user_pin_oe_n[i]) begin
                pin_level[i] = user_pin_out[i];
            end else if (ext_en[i]) begin
                pin_level[i] = ext_val[i];
            end else begin
                // No pull on these pads, so never show a stable stale value
                pin_level[i] = ~last_level[i];
            end
        end
    end

    // Remember the level so an undriven pad changes every cycle
    always_ff @(posedge core_clk) begin
        last_level <= pin_level;
    end

    // Pad feeds the input buffer; both sides driving is a contention
    assign user_pin_in = pin_level;
    assign clash = ~user_pin_oe_n & ext_en;
endmodule : crp_pin_model
`default_nettype wire

// ---- tb/test_core_regs_user_port.sv ----
// Self-checking bench for the core registers and user port block
`timescale 1ns/1ps
`default_nettype none
module test_core_regs_user_port
    import crp_pkg::*;
;
    localparam int PINS = USER_PINS;
    logic core_clk = 1'b0; // 200 MHz core clock
    logic reset_n = 1'b0; // Active low reset
    crp_sfr_req_t sfr_req = '0;
    logic [7:0] sfr_rdata;
    crp_op_t reg_op = CRP_OP_NONE;
    logic [15:0] ptr_imm = '0;
    logic [7:0] aux_result = '0;
    logic operand_we = 1'b0;
    logic [7:0] operand_wdata = '0;
    logic arith_we = 1'b0;
    crp_arith_flags_t arith_flags = '0;
    logic fetch_adv = 1'b0;
    logic fetch_load = 1'b0;
    logic [15:0] fetch_target = '0;
    logic [7:0] stack_top_reg, core_flags_reg, main_operand_reg, aux_reg, rd;
    logic [15:0] ext_data_pointer, instr_fetch_counter;
    logic [4:0] bank_base;
    logic [PINS-1:0] user_pin_in, user_pin_out, user_pin_oe_n, pin_level, clash;
    logic [PINS-1:0] ext_val = 9'h1a5; // Board drive pattern
    logic [PINS-1:0] ext_en = 9'h1ff; // Board drives all pins at reset
    int n_mismatch = 0;
    int checks = 0;

    always #2.5 core_clk = ~core_clk;

    crp_core_regs #(.PINS(PINS)) dut_u (
        .core_clk(core_clk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .reg_op(reg_op), .ptr_imm(ptr_imm), .aux_result(aux_result),
        .operand_we(operand_we), .operand_wdata(operand_wdata), .arith_we(arith_we),
        .arith_flags(arith_flags), .fetch_adv(fetch_adv), .fetch_load(fetch_load),
        .fetch_target(fetch_target), .stack_top_reg(stack_top_reg),
        .ext_data_pointer(ext_data_pointer), .instr_fetch_counter(instr_fetch_counter),
        .core_flags_reg(core_flags_reg), .main_operand_reg(main_operand_reg),
        .aux_reg(aux_reg), .bank_base(bank_base), .user_pin_in(user_pin_in),
        .user_pin_out(user_pin_out), .user_pin_oe_n(user_pin_oe_n));

    crp_pin_model #(.PINS(PINS)) pins_u (
        .core_clk(core_clk), .user_pin_out(user_pin_out), .user_pin_oe_n(user_pin_oe_n),
        .ext_val(ext_val), .ext_en(ext_en), .pin_level(pin_level),
        .user_pin_in(user_pin_in), .clash(clash));

    // Compare a register or pin value, zero-extended to 16 bits
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Wait whole cycles, ending at a falling edge
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick

    // One-cycle register write pulse
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        tick(1);
        sfr_req = '0;
        tick(1);
    endtask : sfr_wr

    // One-cycle read pulse; data holds until the next read
    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        tick(1);
        sfr_req = '0;
        tick(1);
        d = sfr_rdata;
    endtask : sfr_rd

    // One-cycle pointer, stack or auxiliary register operation; idle cycle keeps calls apart
    task automatic op(input crp_op_t o);
        reg_op = o;
        tick(1);
        reg_op = CRP_OP_NONE;
        tick(1);
    endtask : op

    // Reset values of registers and pin drivers
    task automatic t_reset();
        chk(stack_top_reg, 16'h0007, "stack");
        chk(instr_fetch_counter, 16'h0000, "counter");
        chk({core_flags_reg, main_operand_reg}, 16'h0000, "flags");
        chk({aux_reg, ext_data_pointer[7:0]}, 16'h0000, "aux");
        chk(user_pin_oe_n, 16'h01ff, "oe_n");
        sfr_rd(ADDR_PINS_LOW_DIR, rd);
        chk(rd, 16'h00ff, "low dir");
        sfr_rd(ADDR_PIN_NINE_DIR, rd);
        chk(rd, 16'h0001, "nine dir");
        $display("t_reset done");
    endtask : t_reset

    // Every bank code, user flags kept, parity write ignored
    task automatic t_flags();
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            v = 8'h23 | {3'b000, i[1:0], 3'b000};
            sfr_wr(ADDR_FLAGS, v);
            chk(core_flags_reg, v & 8'hfe, "flags");
            chk(bank_base, {i[1:0], 3'b000}, "bank");
        end
        sfr_rd(ADDR_FLAGS, rd);
        chk(rd, 16'h003a, "flags read");
        $display("t_flags done");
    endtask : t_flags

    // Parity follows the accumulator from both write paths
    task automatic t_parity();
        logic [7:0] vals [6] = '{8'h01, 8'h03, 8'h80, 8'hfe, 8'hff, 8'h00};
        operand_we = 1'b1;
        foreach (vals[i]) begin
            operand_wdata = vals[i];
            tick(1);
            chk(main_operand_reg, vals[i], "operand");
            chk(core_flags_reg[0], ^vals[i], "parity");
        end
        operand_we = 1'b0;
        sfr_wr(ADDR_OPERAND, 8'h07);
        chk(core_flags_reg[0], 16'h0001, "parity sw");
        sfr_rd(ADDR_OPERAND, rd);
        chk(rd, 16'h0007, "operand read");
        $display("t_parity done");
    endtask : t_parity

    // All combinations of carry, half carry and overflow
    task automatic t_arith();
        arith_we = 1'b1;
        for (int k = 0; k < 8; k++) begin
            arith_flags = k[2:0];
            tick(1);
            chk({core_flags_reg[7:6], core_flags_reg[2]}, k[2:0], "arith");
        end
        arith_we = 1'b0;
        $display("t_arith done");
    endtask : t_arith

    // Pre-increment stack, wrap at the top of the byte
    task automatic t_stack();
        op(CRP_OP_PUSH);
        chk(stack_top_reg, 16'h0008, "push");
        op(CRP_OP_PUSH);
        op(CRP_OP_POP);
        chk(stack_top_reg, 16'h0008, "pop");
        sfr_wr(ADDR_STACK_TOP, 8'hff);
        op(CRP_OP_PUSH);
        sfr_rd(ADDR_STACK_TOP, rd);
        chk(rd, 16'h0000, "wrap");
        $display("t_stack done");
    endtask : t_stack

    // Pointer as one word and as two bytes; auxiliary register paths
    task automatic t_ptr_aux();
        ptr_imm = 16'hbeef;
        op(CRP_OP_LOAD_PTR16);
        chk(ext_data_pointer, 16'hbeef, "ptr16");
        sfr_rd(ADDR_PTR_HIGH, rd);
        chk(rd, 16'h00be, "ptr high");
        sfr_wr(ADDR_PTR_LOW, 8'h34);
        sfr_wr(ADDR_PTR_HIGH, 8'h12);
        chk(ext_data_pointer, 16'h1234, "ptr bytes");
        aux_result = 8'h5a;
        op(CRP_OP_MULDIV);
        chk(aux_reg, 16'h005a, "muldiv");
        sfr_wr(ADDR_AUX, 8'ha5);
        sfr_rd(ADDR_AUX, rd);
        chk(rd, 16'h00a5, "aux read");
        $display("t_ptr_aux done");
    endtask : t_ptr_aux

    // Fetch counter advances, loads and is out of register reach
    task automatic t_fetch();
        fetch_adv = 1'b1;
        tick(3);
        fetch_adv = 1'b0;
        chk(instr_fetch_counter, 16'h0003, "advance");
        for (int a = 8'h80; a < 8'h90; a += 4) begin
            sfr_wr(a[7:0], 8'h55);
        end
        chk(instr_fetch_counter, 16'h0003, "no access");
        sfr_rd(8'h80, rd);
        chk(rd, 16'h0000, "unmapped");
        fetch_target = 16'hfffe;
        fetch_load = 1'b1;
        tick(1);
        fetch_load = 1'b0;
        fetch_adv = 1'b1;
        tick(2);
        fetch_adv = 1'b0;
        chk(instr_fetch_counter, 16'h0000, "wrap");
        $display("t_fetch done");
    endtask : t_fetch

    // Pins as inputs, mixed directions, and the ninth pin
    task automatic t_port();
        tick(5);
        sfr_rd(ADDR_PINS_LOW_DATA, rd);
        chk(rd, 16'h00a5, "low in");
        sfr_rd(ADDR_PIN_NINE_DATA, rd);
        chk(rd, 16'h0001, "nine in");
        // Board lets go before the device starts driving
        ext_en = 9'h1f0;
        sfr_wr(ADDR_PINS_LOW_DATA, 8'h3c);
        sfr_wr(ADDR_PINS_LOW_DIR, 8'hf0);
        tick(5);
        chk(user_pin_oe_n, 16'h01f0, "mixed oe_n");
        chk(pin_level[3:0], 16'h000c, "pins out");
        sfr_rd(ADDR_PINS_LOW_DATA, rd);
        chk(rd, 16'h00ac, "mixed read");
        sfr_wr(ADDR_PINS_LOW_DATA, 8'hc3);
        tick(2);
        chk(pin_level[3:0], 16'h0003, "pins flip");
        ext_en = 9'h0f0;
        sfr_wr(ADDR_PIN_NINE_DATA, 8'hff);
        sfr_wr(ADDR_PIN_NINE_DIR, 8'h00);
        tick(5);
        chk({user_pin_oe_n[8], pin_level[8]}, 16'h0001, "nine out");
        sfr_wr(ADDR_PIN_NINE_DATA, 8'hfe);
        tick(5);
        chk(pin_level[8], 16'h0000, "nine low");
        sfr_rd(ADDR_PIN_NINE_DATA, rd);
        chk(rd, 16'h00fe, "nine read");
        chk(clash, 16'h0000, "contention");
        $display("t_port done");
    endtask : t_port

    // Count summary, verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // Main sequence: reset for six cycles, then every scenario
    initial begin
        tick(6);
        reset_n = 1'b1;
        tick(1);
        t_reset();
        t_flags();
        t_parity();
        t_arith();
        t_stack();
        t_ptr_aux();
        t_fetch();
        t_port();
        conclude();
    end

    // Watchdog: the tests need well under 1000 cycles
    initial begin
        #20000;
        n_mismatch++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end
endmodule : test_core_regs_user_port
`default_nettype wire
